// [pkg/exec_pkg.sv]
package exec_pkg;
    // ==============================================
    // Widths and reset values
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int PC_W = 16;
    localparam int REG_CNT = 32;
    localparam int IO_CNT = 32;
    localparam int IDX_W = 5;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    // ==============================================
    // Status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ==============================================
    // Opcode masks and patterns
    localparam logic [15:0] M_RR = 16'hfc00;
    localparam logic [15:0] P_CMP_SKIP = 16'h1000;
    localparam logic [15:0] P_CMP = 16'h1400;
    localparam logic [15:0] P_CMP_CARRY = 16'h0400;
    localparam logic [15:0] P_SHL = 16'h0c00;
    localparam logic [15:0] P_RLC = 16'h1c00;
    localparam logic [15:0] M_IMM = 16'hf000;
    localparam logic [15:0] P_CMP_IMM = 16'h3000;
    localparam logic [15:0] M_RBIT = 16'hfe08;
    localparam logic [15:0] P_SKRC = 16'hfc00;
    localparam logic [15:0] P_SKRS = 16'hfe00;
    localparam logic [15:0] P_TSTORE = 16'hfa00;
    localparam logic [15:0] P_TLOAD = 16'hf800;
    localparam logic [15:0] M_IO = 16'hff00;
    localparam logic [15:0] P_SKIC = 16'h9900;
    localparam logic [15:0] P_SKIS = 16'h9b00;
    localparam logic [15:0] P_IOSET = 16'h9a00;
    localparam logic [15:0] P_IOCLR = 16'h9800;
    localparam logic [15:0] M_BR = 16'hfc00;
    localparam logic [15:0] P_BRS = 16'hf000;
    localparam logic [15:0] P_BRC = 16'hf400;
    localparam logic [15:0] M_ONE = 16'hfe0f;
    localparam logic [15:0] P_SHR = 16'h9406;
    localparam logic [15:0] P_RRC = 16'h9407;
    localparam logic [15:0] P_SAR = 16'h9405;
    localparam logic [15:0] P_LDS = 16'h9000;
    localparam logic [15:0] P_STS = 16'h9200;
    localparam logic [15:0] M_FLAG = 16'hff8f;
    localparam logic [15:0] P_FSET = 16'h9408;
    localparam logic [15:0] P_FCLR = 16'h9488;
    localparam logic [15:0] M_LONG = 16'hfe0e;
    localparam logic [15:0] P_JUMP = 16'h940c;
    localparam logic [15:0] P_CALL = 16'h940e;

    typedef enum logic [2:0] {
        ALU_NONE, ALU_CMP, ALU_CMPC, ALU_SHL, ALU_RLC, ALU_SHR, ALU_RRC, ALU_SAR
    } alu_op_type;

    typedef enum logic [3:0] {
        ST_EXEC = 4'b0001,
        ST_SKIP = 4'b0010,
        ST_TAIL = 4'b0100,
        ST_STALL = 4'b1000
    } state_type;

    function automatic logic op_is(input logic [15:0] w, input logic [15:0] m,
                                   input logic [15:0] p);
        return (w & m) == p;
    endfunction

    function automatic logic is_two_word(input logic [15:0] w);
        return op_is(w, M_LONG, P_JUMP) || op_is(w, M_LONG, P_CALL) ||
               op_is(w, M_ONE, P_LDS) || op_is(w, M_ONE, P_STS);
    endfunction

    function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] b);
        return 8'h01 << b;
    endfunction
endpackage

// [verilog/exec_alu.sv]
`timescale 1ns/1ps
module exec_alu (
    input wire exec_pkg::alu_op_type i_op,
    input wire logic [7:0] i_dst,
    input wire logic [7:0] i_src,
    input wire logic [7:0] i_status,
    output logic [7:0] o_result,
    output logic [7:0] o_status
);
    logic [8:0] diff;
    logic cin;
    logic cout;

    always_comb begin
        cin = (i_op == exec_pkg::ALU_CMPC) ? i_status[exec_pkg::FLAG_C] : 1'b0;
        diff = {1'b0, i_dst} - {1'b0, i_src} - {8'h00, cin};
        o_result = exec_pkg::DATA_ZERO;
        o_status = i_status;
        cout = 1'b0;
        case (i_op)
            exec_pkg::ALU_CMP, exec_pkg::ALU_CMPC: begin
                o_result = diff[7:0]; // RULE2
                o_status[exec_pkg::FLAG_H] = (~i_dst[3] & i_src[3]) | (i_src[3] & diff[3]) |
                                             (diff[3] & ~i_dst[3]);
                o_status[exec_pkg::FLAG_V] = (i_dst[7] & ~i_src[7] & ~diff[7]) |
                                             (~i_dst[7] & i_src[7] & diff[7]);
                o_status[exec_pkg::FLAG_N] = diff[7];
                o_status[exec_pkg::FLAG_C] = (~i_dst[7] & i_src[7]) | (i_src[7] & diff[7]) |
                                             (diff[7] & ~i_dst[7]);
                // Carry form only keeps Z, so multi-byte compares chain
                o_status[exec_pkg::FLAG_Z] = (diff[7:0] == exec_pkg::DATA_ZERO) &&
                    (i_op == exec_pkg::ALU_CMP || i_status[exec_pkg::FLAG_Z]);
            end
            exec_pkg::ALU_SHL: begin
                o_result = {i_dst[6:0], 1'b0}; // RULE11
                cout = i_dst[7];
            end
            exec_pkg::ALU_RLC: begin
                o_result = {i_dst[6:0], i_status[exec_pkg::FLAG_C]}; // RULE11
                cout = i_dst[7];
            end
            exec_pkg::ALU_SHR: begin
                o_result = {1'b0, i_dst[7:1]}; // RULE12
                cout = i_dst[0];
            end
            exec_pkg::ALU_RRC: begin
                o_result = {i_status[exec_pkg::FLAG_C], i_dst[7:1]}; // RULE12
                cout = i_dst[0];
            end
            exec_pkg::ALU_SAR: begin
                o_result = {i_dst[7], i_dst[7:1]}; // RULE12
                cout = i_dst[0];
            end
            default: begin
                o_result = i_dst;
            end
        endcase
        if (i_op inside {exec_pkg::ALU_SHL, exec_pkg::ALU_RLC, exec_pkg::ALU_SHR,
                         exec_pkg::ALU_RRC, exec_pkg::ALU_SAR}) begin
            o_status[exec_pkg::FLAG_C] = cout;
            o_status[exec_pkg::FLAG_N] = o_result[7];
            o_status[exec_pkg::FLAG_V] = o_result[7] ^ cout;
            o_status[exec_pkg::FLAG_Z] = (o_result == exec_pkg::DATA_ZERO);
        end
    end
endmodule

// [verilog/cpu_branch_bit_shift_exec.sv]
`timescale 1ns/1ps
// How it works
// RULE1 - Equal registers skip the next instruction
// RULE2 - Compares set Z N V C H, no write
// RULE3 - Register bit test skips next instruction
// RULE4 - I/O bit test skips next instruction
// RULE5 - Status bit branch to PC plus k plus one
// RULE6 - Zero and carry conditions branch
// RULE7 - Negative and signed conditions branch
// RULE8 - Half carry and T conditions branch
// RULE9 - Overflow and interrupt enable conditions branch
// RULE10 - Set or clear I/O bit, two cycles
// RULE11 - Left shift and rotate update four flags
// RULE12 - Right shifts and rotate update four flags
// RULE13 - Set or clear one status bit only
// RULE14 - Move bits between register and T flag
// RULE15 - Skip covers whole next instruction length
module cpu_branch_bit_shift_exec (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic [15:0] i_instr_word,
    input wire logic i_dbg_reg_we,
    input wire logic [4:0] i_dbg_reg_addr,
    input wire logic [7:0] i_dbg_reg_data,
    input wire logic i_dbg_io_we,
    input wire logic [4:0] i_dbg_io_addr,
    input wire logic [7:0] i_dbg_io_data,
    output logic [15:0] o_pc,
    output logic [7:0] o_status,
    output logic o_busy,
    output logic [7:0] o_dbg_reg_data,
    output logic [7:0] o_dbg_io_data
);
    // ==========================================
    // Instruction fields
    // Slicing kept in one place so every decoder agrees
    function automatic logic [4:0] field_dst(input logic [15:0] w);
        return w[8:4];
    endfunction

    function automatic logic [4:0] field_src(input logic [15:0] w);
        return {w[9], w[3:0]};
    endfunction

    // Immediate forms reach only the upper sixteen registers
    function automatic logic [4:0] field_upper(input logic [15:0] w);
        return {1'b1, w[7:4]};
    endfunction

    function automatic logic [7:0] field_imm(input logic [15:0] w);
        return {w[11:8], w[3:0]};
    endfunction

    function automatic logic [4:0] field_io(input logic [15:0] w);
        return w[7:3];
    endfunction

    function automatic logic [2:0] field_low(input logic [15:0] w);
        return w[2:0];
    endfunction

    function automatic logic [2:0] field_flag(input logic [15:0] w);
        return w[6:4];
    endfunction

    function automatic logic [15:0] branch_target(input logic [15:0] pc,
                                                  input logic [15:0] w);
        return pc + {{9{w[9]}}, w[9:3]} + exec_pkg::PC_STEP;
    endfunction

    // ==========================================
    // Storage and state
    logic [7:0] reg_file [0:exec_pkg::REG_CNT-1];
    logic [7:0] io_file [0:exec_pkg::IO_CNT-1];
    logic [15:0] pc_reg;
    logic [15:0] pc_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    exec_pkg::state_type state_reg;
    exec_pkg::state_type state_next;
    logic busy_reg;
    logic [7:0] reg_view_reg;
    logic [7:0] io_view_reg;

    // ==========================================
    // Decode
    logic [15:0] word;
    logic do_exec;
    logic is_cmp_skip;
    logic is_cmp;
    logic is_cmp_carry;
    logic is_cmp_imm;
    logic is_shl;
    logic is_rlc;
    logic is_shr;
    logic is_rrc;
    logic is_sar;
    logic is_shift;
    logic is_skip_reg_clear;
    logic is_skip_reg_set;
    logic is_skip_io_clear;
    logic is_skip_io_set;
    logic is_branch_set;
    logic is_branch_clear;
    logic is_io_set;
    logic is_io_clear;
    logic is_flag_set;
    logic is_flag_clear;
    logic is_tstore;
    logic is_tload;
    logic [4:0] dst_idx;
    logic [4:0] src_idx;
    logic [4:0] io_idx;
    logic [2:0] bit_idx;
    logic [2:0] flag_idx;
    logic [7:0] dst_val;
    logic [7:0] src_val;
    logic [7:0] io_val;
    logic flag_val;
    logic skip_hit;
    logic branch_hit;
    logic io_wr;
    logic [7:0] io_wdata;
    logic reg_wr;
    logic [7:0] reg_wdata;
    exec_pkg::alu_op_type alu_op;
    logic [7:0] alu_src;
    logic [7:0] alu_result;
    logic [7:0] alu_status;

    assign word = i_instr_word;
    assign do_exec = i_run && (state_reg == exec_pkg::ST_EXEC);
    assign is_cmp_skip = exec_pkg::op_is(word, exec_pkg::M_RR, exec_pkg::P_CMP_SKIP);
    assign is_cmp = exec_pkg::op_is(word, exec_pkg::M_RR, exec_pkg::P_CMP);
    assign is_cmp_carry = exec_pkg::op_is(word, exec_pkg::M_RR, exec_pkg::P_CMP_CARRY);
    assign is_cmp_imm = exec_pkg::op_is(word, exec_pkg::M_IMM, exec_pkg::P_CMP_IMM);
    // Left shifts share the add encoding; only equal operands count
    assign is_shl = exec_pkg::op_is(word, exec_pkg::M_RR, exec_pkg::P_SHL) &&
                    (field_dst(word) == field_src(word));
    assign is_rlc = exec_pkg::op_is(word, exec_pkg::M_RR, exec_pkg::P_RLC) &&
                    (field_dst(word) == field_src(word));
    assign is_shr = exec_pkg::op_is(word, exec_pkg::M_ONE, exec_pkg::P_SHR);
    assign is_rrc = exec_pkg::op_is(word, exec_pkg::M_ONE, exec_pkg::P_RRC);
    assign is_sar = exec_pkg::op_is(word, exec_pkg::M_ONE, exec_pkg::P_SAR);
    assign is_shift = is_shl || is_rlc || is_shr || is_rrc || is_sar;
    assign is_skip_reg_clear = exec_pkg::op_is(word, exec_pkg::M_RBIT, exec_pkg::P_SKRC);
    assign is_skip_reg_set = exec_pkg::op_is(word, exec_pkg::M_RBIT, exec_pkg::P_SKRS);
    assign is_skip_io_clear = exec_pkg::op_is(word, exec_pkg::M_IO, exec_pkg::P_SKIC);
    assign is_skip_io_set = exec_pkg::op_is(word, exec_pkg::M_IO, exec_pkg::P_SKIS);
    assign is_branch_set = exec_pkg::op_is(word, exec_pkg::M_BR, exec_pkg::P_BRS);
    assign is_branch_clear = exec_pkg::op_is(word, exec_pkg::M_BR, exec_pkg::P_BRC);
    assign is_io_set = exec_pkg::op_is(word, exec_pkg::M_IO, exec_pkg::P_IOSET);
    assign is_io_clear = exec_pkg::op_is(word, exec_pkg::M_IO, exec_pkg::P_IOCLR);
    assign is_flag_set = exec_pkg::op_is(word, exec_pkg::M_FLAG, exec_pkg::P_FSET);
    assign is_flag_clear = exec_pkg::op_is(word, exec_pkg::M_FLAG, exec_pkg::P_FCLR);
    assign is_tstore = exec_pkg::op_is(word, exec_pkg::M_RBIT, exec_pkg::P_TSTORE);
    assign is_tload = exec_pkg::op_is(word, exec_pkg::M_RBIT, exec_pkg::P_TLOAD);

    assign dst_idx = is_cmp_imm ? field_upper(word) : field_dst(word);
    assign src_idx = field_src(word);
    assign io_idx = field_io(word);
    assign bit_idx = field_low(word);
    assign flag_idx = field_flag(word);
    assign dst_val = reg_file[dst_idx];
    assign src_val = reg_file[src_idx];
    assign io_val = io_file[io_idx];
    assign flag_val = status_reg[bit_idx];

    // ==========================================
    // Conditions
    assign skip_hit = (is_cmp_skip && (dst_val == src_val)) || // RULE1
                      (is_skip_reg_clear && !dst_val[bit_idx]) || // RULE3
                      (is_skip_reg_set && dst_val[bit_idx]) || // RULE3
                      (is_skip_io_clear && !io_val[bit_idx]) || // RULE4
                      (is_skip_io_set && io_val[bit_idx]); // RULE4
    // Named flag branches are this pair with a fixed bit select
    assign branch_hit = (is_branch_set && flag_val) || // RULE5 RULE6 RULE8 RULE9
                        (is_branch_clear && !flag_val); // RULE5 RULE6 RULE7 RULE9

    // ==========================================
    // Arithmetic
    always_comb begin
        alu_op = exec_pkg::ALU_NONE;
        alu_src = src_val;
        if (is_cmp || is_cmp_imm) begin
            alu_op = exec_pkg::ALU_CMP; // RULE2
        end else if (is_cmp_carry) begin
            alu_op = exec_pkg::ALU_CMPC; // RULE2
        end else if (is_shl) begin
            alu_op = exec_pkg::ALU_SHL; // RULE11
        end else if (is_rlc) begin
            alu_op = exec_pkg::ALU_RLC; // RULE11
        end else if (is_shr) begin
            alu_op = exec_pkg::ALU_SHR; // RULE12
        end else if (is_rrc) begin
            alu_op = exec_pkg::ALU_RRC; // RULE12
        end else if (is_sar) begin
            alu_op = exec_pkg::ALU_SAR; // RULE12
        end
        if (is_cmp_imm) begin
            alu_src = field_imm(word); // RULE2
        end
    end

    exec_alu alu_u (
        .i_op(alu_op),
        .i_dst(dst_val),
        .i_src(alu_src),
        .i_status(status_reg),
        .o_result(alu_result),
        .o_status(alu_status)
    );

    // ==========================================
    // Program counter and sequencing
    always_comb begin
        pc_next = pc_reg;
        state_next = state_reg;
        if (i_run) begin
            case (state_reg)
                exec_pkg::ST_EXEC: begin
                    pc_next = pc_reg + exec_pkg::PC_STEP;
                    state_next = exec_pkg::ST_EXEC;
                    if (skip_hit) begin
                        state_next = exec_pkg::ST_SKIP; // RULE1
                    end else if (branch_hit) begin
                        pc_next = branch_target(pc_reg, word); // RULE5
                        state_next = exec_pkg::ST_STALL;
                    end else if (io_wr) begin
                        state_next = exec_pkg::ST_STALL; // RULE10
                    end
                end
                exec_pkg::ST_SKIP: begin
                    // Skipped word only measured, never executed
                    pc_next = pc_reg + exec_pkg::PC_STEP;
                    state_next = exec_pkg::ST_EXEC;
                    if (exec_pkg::is_two_word(word)) begin
                        pc_next = pc_reg + exec_pkg::PC_STEP + exec_pkg::PC_STEP; // RULE15
                        state_next = exec_pkg::ST_TAIL;
                    end
                end
                exec_pkg::ST_TAIL: begin
                    state_next = exec_pkg::ST_EXEC;
                end
                exec_pkg::ST_STALL: begin
                    state_next = exec_pkg::ST_EXEC;
                end
                default: begin
                    state_next = exec_pkg::ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            pc_reg <= exec_pkg::PC_RESET;
            state_reg <= exec_pkg::ST_EXEC;
            busy_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            state_reg <= state_next;
            busy_reg <= (state_next != exec_pkg::ST_EXEC);
        end
    end

    // ==========================================
    // Status register
    always_comb begin
        status_next = status_reg;
        if (do_exec && (alu_op != exec_pkg::ALU_NONE)) begin
            status_next = alu_status; // RULE2 RULE11 RULE12
            // Signed branches test this bit, so it tracks N xor V
            status_next[exec_pkg::FLAG_S] = alu_status[exec_pkg::FLAG_N] ^
                                            alu_status[exec_pkg::FLAG_V]; // RULE7
        end else if (do_exec && is_flag_set) begin
            status_next[flag_idx] = 1'b1; // RULE13
        end else if (do_exec && is_flag_clear) begin
            status_next[flag_idx] = 1'b0; // RULE13
        end else if (do_exec && is_tstore) begin
            status_next[exec_pkg::FLAG_T] = dst_val[bit_idx]; // RULE14
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            status_reg <= exec_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ==========================================
    // Working registers
    always_comb begin
        reg_wr = 1'b0;
        reg_wdata = alu_result;
        if (do_exec && is_shift) begin
            reg_wr = 1'b1; // RULE11 RULE12
        end else if (do_exec && is_tload) begin
            reg_wr = 1'b1; // RULE14
            reg_wdata = (dst_val & ~exec_pkg::bit_mask(bit_idx)) |
                        (status_reg[exec_pkg::FLAG_T] ? exec_pkg::bit_mask(bit_idx) :
                         exec_pkg::DATA_ZERO);
        end
    end

    // Execution wins over a debug write to the same register
    generate
        for (genvar g = 0; g < exec_pkg::REG_CNT; g++) begin : g_reg
            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    reg_file[g] <= exec_pkg::DATA_ZERO;
                end else if (reg_wr && (dst_idx == 5'(g))) begin
                    reg_file[g] <= reg_wdata;
                end else if (i_dbg_reg_we && (i_dbg_reg_addr == 5'(g))) begin
                    reg_file[g] <= i_dbg_reg_data;
                end
            end
        end
    endgenerate

    // ==========================================
    // I/O registers
    assign io_wr = do_exec && (is_io_set || is_io_clear); // RULE10
    assign io_wdata = is_io_set ? (io_val | exec_pkg::bit_mask(bit_idx)) :
                      (io_val & ~exec_pkg::bit_mask(bit_idx)); // RULE10

    generate
        for (genvar g = 0; g < exec_pkg::IO_CNT; g++) begin : g_io
            always_ff @(posedge i_clock) begin
                if (!i_nrst) begin
                    io_file[g] <= exec_pkg::DATA_ZERO;
                end else if (io_wr && (io_idx == 5'(g))) begin
                    io_file[g] <= io_wdata;
                end else if (i_dbg_io_we && (i_dbg_io_addr == 5'(g))) begin
                    io_file[g] <= i_dbg_io_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            reg_view_reg <= exec_pkg::DATA_ZERO;
            io_view_reg <= exec_pkg::DATA_ZERO;
        end else begin
            reg_view_reg <= reg_file[i_dbg_reg_addr];
            io_view_reg <= io_file[i_dbg_io_addr];
        end
    end

    assign o_pc = pc_reg;
    assign o_status = status_reg;
    assign o_busy = busy_reg;
    assign o_dbg_reg_data = reg_view_reg;
    assign o_dbg_io_data = io_view_reg;

    // ==========================================
    // Checks
    default clocking main_cb @(posedge i_clock);
    endclocking

    default disable iff (!i_nrst);

    property p_skip_enter;
        do_exec && skip_hit |=> state_reg == exec_pkg::ST_SKIP &&
            pc_reg == $past(pc_reg) + exec_pkg::PC_STEP;
    endproperty

    property p_skip_short;
        state_reg == exec_pkg::ST_SKIP && i_run && !exec_pkg::is_two_word(word) |=>
            state_reg == exec_pkg::ST_EXEC && pc_reg == $past(pc_reg) + exec_pkg::PC_STEP;
    endproperty

    property p_skip_long;
        state_reg == exec_pkg::ST_SKIP && i_run && exec_pkg::is_two_word(word) |=>
            state_reg == exec_pkg::ST_TAIL &&
            pc_reg == $past(pc_reg) + exec_pkg::PC_STEP + exec_pkg::PC_STEP;
    endproperty

    property p_branch_taken;
        do_exec && branch_hit |=> state_reg == exec_pkg::ST_STALL &&
            pc_reg == branch_target($past(pc_reg), $past(word));
    endproperty

    property p_branch_not_taken;
        do_exec && (is_branch_set || is_branch_clear) && !branch_hit |=>
            state_reg == exec_pkg::ST_EXEC && pc_reg == $past(pc_reg) + exec_pkg::PC_STEP;
    endproperty

    property p_io_two_cycles;
        io_wr |=> state_reg == exec_pkg::ST_STALL &&
            io_file[$past(io_idx)][$past(bit_idx)] == $past(is_io_set);
    endproperty

    property p_compare_keeps;
        do_exec && (is_cmp || is_cmp_carry || is_cmp_imm) && !i_dbg_reg_we |=>
            reg_file[$past(dst_idx)] == $past(dst_val);
    endproperty

    property p_flag_set;
        do_exec && is_flag_set |=>
            status_reg == ($past(status_reg) | exec_pkg::bit_mask($past(flag_idx)));
    endproperty

    property p_flag_clear;
        do_exec && is_flag_clear |=>
            status_reg == ($past(status_reg) & ~exec_pkg::bit_mask($past(flag_idx)));
    endproperty

    AST_SKIP_ENTER: assert property (p_skip_enter) else $error("skip not entered"); // RULE1
    AST_SKIP_SHORT: assert property (p_skip_short) else $error("short skip wrong"); // RULE3
    AST_SKIP_LONG: assert property (p_skip_long) else $error("long skip wrong"); // RULE15
    AST_BRANCH_TAKEN: assert property (p_branch_taken) else $error("branch wrong"); // RULE5
    AST_BRANCH_NOT_TAKEN: assert property (p_branch_not_taken) else $error("fall wrong"); // RULE6
    AST_IO_TWO_CYCLES: assert property (p_io_two_cycles) else $error("io bit wrong"); // RULE10
    AST_COMPARE_KEEPS: assert property (p_compare_keeps) else $error("compare wrote"); // RULE2
    AST_FLAG_SET: assert property (p_flag_set) else $error("flag set wrong"); // RULE13
    AST_FLAG_CLEAR: assert property (p_flag_clear) else $error("flag clear wrong"); // RULE13

    COV_SKIP_LONG: cover property (state_reg == exec_pkg::ST_SKIP && i_run &&
                                   exec_pkg::is_two_word(word));
    COV_BRANCH_TAKEN: cover property (do_exec && branch_hit);
    COV_IO_WRITE: cover property (io_wr);
    COV_SHIFT: cover property (do_exec && is_shift);
endmodule

// [verification/prog_mem_model.sv]
`timescale 1ns/1ps
// ==========================================
// Program memory, answers in the same cycle
module prog_mem_model (
    input wire logic [15:0] i_addr,
    output logic [15:0] o_word
);
    logic [15:0] mem [0:15];
    // Small store; upper address bits ignored
    assign o_word = mem[i_addr[3:0]];
endmodule

// [verification/cpu_branch_bit_shift_exec_test.sv]
`timescale 1ns/1ps
module cpu_branch_bit_shift_exec_test;
    logic i_clock, i_nrst, i_run, reg_we, io_we;
    logic [15:0] word, pc;
    logic [4:0] addr;
    logic [7:0] wdata, status, reg_q, io_q;
    logic busy;
    int n_fail = 0;
    int n_checks = 0;
    // Skip, compare, branch, set io bit, shift, set T, load bit, self loop
    logic [15:0] prog [0:10] = '{16'h1301, 16'h0000, 16'h1702, 16'hf010, 16'h0000,
        16'h0000, 16'h9a2b, 16'h0f22, 16'h9468, 16'hf901, 16'hf3f9};
    // Immediate compare, long and short skips over flag setters, clear io bit,
    // right shifts, untaken branch, T store, flag clear, self loop
    logic [15:0] prog2 [0:13] = '{16'h3801, 16'hff07, 16'h9000, 16'h9458, 16'h9921,
        16'h9458, 16'h9820, 16'h9505, 16'hf408, 16'h9507, 16'hfb05, 16'h94a8,
        16'h9506, 16'hf7f9};
    cpu_branch_bit_shift_exec dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_run(i_run),
        .i_instr_word(word), .i_dbg_reg_we(reg_we), .i_dbg_reg_addr(addr),
        .i_dbg_reg_data(wdata), .i_dbg_io_we(io_we), .i_dbg_io_addr(addr),
        .i_dbg_io_data(wdata), .o_pc(pc), .o_status(status), .o_busy(busy),
        .o_dbg_reg_data(reg_q), .o_dbg_io_data(io_q));
    prog_mem_model mem_u (.i_addr(pc), .o_word(word));
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    task automatic tick();
        @(posedge i_clock);
        #2;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic poke(input logic io, input logic [4:0] a, input logic [7:0] d);
        reg_we = !io;
        io_we = io;
        addr = a;
        wdata = d;
        tick();
        reg_we = 1'b0;
        io_we = 1'b0;
    endtask
    task automatic peek(input string name, input logic io, input logic [4:0] a,
                        input logic [7:0] exp);
        addr = a;
        tick();
        check(name, {8'h00, exp}, {8'h00, io ? io_q : reg_q});
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Watchdog, far beyond the roughly 160 cycles needed
    initial begin
        repeat (3000) @(posedge i_clock);
        n_fail++;
        complete_run();
    end
    initial begin
        i_nrst = 1'b0;
        i_run = 1'b0;
        reg_we = 1'b0;
        io_we = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        for (int i = 0; i < 16; i++) mem_u.mem[i] = (i < 11) ? prog[i] : 16'h0000;
        repeat (16) tick();
        i_nrst = 1'b1;
        tick();
        check("pc after reset", exec_pkg::PC_RESET, pc);
        check("status after reset", {8'h00, exec_pkg::STATUS_RESET}, {8'h00, status});
        check("busy after reset", 16'h0000, {15'h0000, busy});
        poke(1'b0, 5'h10, 8'h55);
        poke(1'b0, 5'h11, 8'h55);
        poke(1'b0, 5'h12, 8'h80);
        poke(1'b1, 5'h05, 8'h00);
        i_run = 1'b1;
        repeat (60) tick();
        i_run = 1'b0;
        tick();
        check("pc at loop", 16'h000a, pc);
        // Sign flag left out: its compare update is not pinned down
        check("flags", 16'h004b, {8'h00, status & 8'hef});
        peek("r16 bit load", 1'b0, 5'h10, 8'h57);
        peek("r17 untouched", 1'b0, 5'h11, 8'h55);
        peek("r18 shifted", 1'b0, 5'h12, 8'h00);
        peek("io5 bit set", 1'b1, 5'h05, 8'h08);
        // Reset while running, then a second program
        i_run = 1'b1;
        tick();
        i_nrst = 1'b0;
        for (int i = 0; i < 16; i++) mem_u.mem[i] = (i < 14) ? prog2[i] : 16'h0000;
        repeat (4) tick();
        i_run = 1'b0;
        i_nrst = 1'b1;
        tick();
        check("pc after second reset", exec_pkg::PC_RESET, pc);
        check("busy after second reset", 16'h0000, {15'h0000, busy});
        poke(1'b0, 5'h10, 8'h81);
        poke(1'b1, 5'h04, 8'h05);
        i_run = 1'b1;
        repeat (60) tick();
        i_run = 1'b0;
        tick();
        check("pc at second loop", 16'h000d, pc);
        check("flags second", 16'h0040, {8'h00, status & 8'hef});
        peek("r16 shifted right", 1'b0, 5'h10, 8'h70);
        peek("io4 bit cleared", 1'b1, 5'h04, 8'h04);
        complete_run();
    end
endmodule
